// File: include/temp_result_pkg.sv
// Purpose: Shared constants of the temperature result register logic.
// Assumes: Byte-level bus engine in front; converter delivers quarter-degree samples.
// Notes: Offsets are register addresses as seen through the address pointer.
package temp_result_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL_RESULT = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_INTEGER = 8'h01;
  localparam logic [7:0] ADDR_REMOTE_FRACTION = 8'h10;
  localparam logic [7:0] ADDR_CONFIG_READ = 8'h03;
  localparam logic [7:0] ADDR_CONFIG_WRITE = 8'h09;
  localparam logic [7:0] ADDR_RATE_READ = 8'h04;
  localparam logic [7:0] ADDR_RATE_WRITE = 8'h0a;
  localparam int REGISTER_COUNT = 22;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_RESULT = 8'h00;
  localparam logic [7:0] RESET_POINTER = 8'h00;
  localparam logic [7:0] RESET_CONFIG = 8'h00;
  localparam logic [7:0] RESET_RATE = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CONFIG_RANGE_BIT = 2;
  localparam logic [7:0] CONFIG_USED_MASK = 8'he4;
  localparam logic [7:0] RATE_USED_MASK = 8'h0f;
  localparam int FRACTION_TOP_BIT = 7;
  localparam int FRACTION_LOW_BIT = 6;

  // ----------------------------------------------------------------
  // Conversion and coding
  // ----------------------------------------------------------------
  localparam int AVERAGE_COUNT = 16;
  localparam logic [3:0] FIRST_FAST_RATE = 4'h8;
  localparam int SAMPLE_WIDTH = 12;
  localparam logic signed [11:0] EXTENDED_OFFSET_Q = 12'sh100;
  localparam logic signed [11:0] BINARY_MAX_Q = 12'sh1fc;
  localparam logic signed [11:0] EXTENDED_MAX_Q = 12'sh3ff;

endpackage

// File: src/temp_sample_averager.sv
// Purpose: Averages a fixed number of samples or passes them straight on.
// Assumes: Samples are signed quarter degrees; count is a power of two.
// Notes: A change of averaging mode restarts the running sum.
`timescale 1ns/1ns
module temp_sample_averager #(
  parameter int WIDTH = temp_result_pkg::SAMPLE_WIDTH,
  parameter int COUNT = temp_result_pkg::AVERAGE_COUNT
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic average_enable,
  input wire logic sample_valid,
  input wire logic signed [WIDTH-1:0] sample,
  output logic result_valid,
  output logic signed [WIDTH-1:0] result
);

  localparam int SHIFT = $clog2(COUNT);

  initial
  begin
    if (COUNT < 2 || (1 << SHIFT) != COUNT || WIDTH < 4)
      $error("averager count must be a power of two, width at least 4");
  end

  logic signed [WIDTH+SHIFT-1:0] sum;
  logic [SHIFT-1:0] taken;
  logic mode_seen;
  logic signed [WIDTH+SHIFT-1:0] next_sum;

  assign next_sum = sum + (WIDTH+SHIFT)'(sample);

  // ----------------------------------------------------------------
  // Running sum
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sum <= '0;
      taken <= '0;
      mode_seen <= 1'b0;
    end
    else
    begin
      mode_seen <= average_enable;
      if (mode_seen != average_enable)
      begin
        sum <= '0;
        taken <= '0;
      end
      else if (sample_valid && average_enable)
      begin
        if (taken == SHIFT'(COUNT - 1))
          sum <= '0;
        else
          sum <= next_sum;
        taken <= taken + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_valid <= 1'b0;
      result <= '0;
    end
    else
    begin
      result_valid <= 1'b0;
      if (mode_seen == average_enable && sample_valid)
      begin
        if (!average_enable)
        begin
          result_valid <= 1'b1;
          result <= sample;
        end
        else if (taken == SHIFT'(COUNT - 1))
        begin
          result_valid <= 1'b1;
          result <= WIDTH'(next_sum >>> SHIFT);
        end
      end
    end
  end

endmodule

// File: src/temp_result_registers.sv
// Purpose: Result registers, coding, remote integer lock from the cycle after a fraction read, and address pointer.
// Assumes: Bus engine gives one-cycle strobes per byte; converter gives samples.
// Notes: Limit comparison, status and alert live elsewhere.
`timescale 1ns/1ns
module temp_result_registers #(
  parameter int WIDTH = temp_result_pkg::SAMPLE_WIDTH,
  parameter int AVG_COUNT = temp_result_pkg::AVERAGE_COUNT
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pointer_write,
  input wire logic data_write,
  input wire logic [7:0] write_byte,
  input wire logic read_request,
  output logic [7:0] read_byte,
  output logic read_valid,
  input wire logic sample_valid,
  input wire logic sample_remote,
  input wire logic signed [WIDTH-1:0] sample_value,
  input wire logic remote_short,
  output logic extended_range,
  output logic [7:0] address_pointer,
  output logic remote_locked
);

  initial
  begin
    if (WIDTH < 12)
      $error("sample width must hold the extended span in quarter degrees");
  end

  logic [7:0] local_temperature_result;
  logic [7:0] remote_temperature_integer;
  logic [7:0] remote_temperature_fraction;
  logic [7:0] config_value;
  logic [7:0] rate_value;
  logic average_enable;
  logic local_valid;
  logic remote_valid;
  logic signed [WIDTH-1:0] local_average;
  logic signed [WIDTH-1:0] remote_average;
  logic [9:0] local_code;
  logic [9:0] remote_code;
  logic [7:0] next_read_byte;

  // ----------------------------------------------------------------
  // Averaging
  // ----------------------------------------------------------------
  assign average_enable = rate_value[3:0] < temp_result_pkg::FIRST_FAST_RATE;

  temp_sample_averager #(
    .WIDTH(WIDTH),
    .COUNT(AVG_COUNT)
  ) local_averager (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .average_enable(average_enable),
    .sample_valid(sample_valid && !sample_remote),
    .sample(sample_value),
    .result_valid(local_valid),
    .result(local_average)
  );

  temp_sample_averager #(
    .WIDTH(WIDTH),
    .COUNT(AVG_COUNT)
  ) remote_averager (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .average_enable(average_enable),
    .sample_valid(sample_valid && sample_remote),
    .sample(sample_value),
    .result_valid(remote_valid),
    .result(remote_average)
  );

  // ----------------------------------------------------------------
  // Coding: quarter degrees to a 10-bit code, integer in the top 8
  // ----------------------------------------------------------------
  function automatic logic [9:0] encode(input logic signed [WIDTH-1:0] q, input logic ext);
    logic signed [WIDTH-1:0] shifted;
    logic [9:0] code;
    shifted = '0;
    code = '0;
    if (ext)
    begin
      shifted = q + WIDTH'(temp_result_pkg::EXTENDED_OFFSET_Q);
      if (shifted < 0)
        code = '0;
      else if (shifted > WIDTH'(temp_result_pkg::EXTENDED_MAX_Q))
        code = 10'h3ff;
      else
        code = shifted[9:0];
    end
    else
    begin
      if (q < 0)
        code = '0;
      else if (q > WIDTH'(temp_result_pkg::BINARY_MAX_Q))
        code = 10'(temp_result_pkg::BINARY_MAX_Q);
      else
        code = q[9:0];
    end
    return code;
  endfunction

  // Live range bit: the result after a switch is coded the new way
  assign local_code = encode(local_average, extended_range);
  assign remote_code = encode(remote_average, extended_range);

  // ----------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      address_pointer <= temp_result_pkg::RESET_POINTER;
    else if (pointer_write)
      address_pointer <= write_byte;
    // Otherwise held across transactions
  end

  // ----------------------------------------------------------------
  // Configuration and rate registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      config_value <= temp_result_pkg::RESET_CONFIG;
      rate_value <= temp_result_pkg::RESET_RATE;
    end
    else if (data_write)
    begin
      // Only these two take writes; limit values are never rewritten here
      if (address_pointer == temp_result_pkg::ADDR_CONFIG_WRITE)
        config_value <= write_byte & temp_result_pkg::CONFIG_USED_MASK;
      else if (address_pointer == temp_result_pkg::ADDR_RATE_WRITE)
        rate_value <= write_byte & temp_result_pkg::RATE_USED_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      extended_range <= 1'b0;
    else if (data_write && address_pointer == temp_result_pkg::ADDR_CONFIG_WRITE)
      extended_range <= write_byte[temp_result_pkg::CONFIG_RANGE_BIT];
  end

  // ----------------------------------------------------------------
  // Remote integer lock, set the cycle after a fraction read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      remote_locked <= 1'b0;
    else if (read_request && address_pointer == temp_result_pkg::ADDR_REMOTE_INTEGER)
      remote_locked <= 1'b0;
    else if (read_request && address_pointer == temp_result_pkg::ADDR_REMOTE_FRACTION)
      remote_locked <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Result registers, written by the converter only
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      local_temperature_result <= temp_result_pkg::RESET_RESULT;
    else if (local_valid)
      local_temperature_result <= local_code[9:2];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remote_temperature_integer <= temp_result_pkg::RESET_RESULT;
      remote_temperature_fraction <= temp_result_pkg::RESET_RESULT;
    end
    else if (remote_valid && !remote_short)
    begin
      if (!remote_locked)
        remote_temperature_integer <= remote_code[9:2];
      remote_temperature_fraction <= {remote_code[1:0], 6'h00};
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    next_read_byte = 8'h00;
    unique case (address_pointer)
      temp_result_pkg::ADDR_LOCAL_RESULT: next_read_byte = local_temperature_result;
      temp_result_pkg::ADDR_REMOTE_INTEGER: next_read_byte = remote_temperature_integer;
      temp_result_pkg::ADDR_REMOTE_FRACTION: next_read_byte = remote_temperature_fraction;
      temp_result_pkg::ADDR_CONFIG_READ: next_read_byte = config_value;
      temp_result_pkg::ADDR_RATE_READ: next_read_byte = rate_value;
      default: next_read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      read_byte <= 8'h00;
      read_valid <= 1'b0;
    end
    else
    begin
      read_valid <= read_request;
      if (read_request)
        read_byte <= next_read_byte;
    end
  end

endmodule

// File: sim/temp_result_props.sv
// Purpose: Port checks on the result register block.
// Assumes: One clock domain, reset_n active low.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ns
module temp_result_props
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic pointer_write,
  input wire logic data_write,
  input wire logic [7:0] write_byte,
  input wire logic read_request,
  input wire logic [7:0] read_byte,
  input wire logic read_valid,
  input wire logic extended_range,
  input wire logic [7:0] address_pointer,
  input wire logic remote_locked
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence frac_read;
    read_request && address_pointer == 8'h10;
  endsequence
  sequence int_read;
    read_request && address_pointer == 8'h01;
  endsequence
  sequence cfg_write;
    data_write && address_pointer == 8'h09;
  endsequence
  read_answer_a: assert property (read_request |=> read_valid)
    else $error("read not answered");
  valid_pulse_a: assert property (!read_request |=> !read_valid)
    else $error("read answer without request");
  byte_hold_a: assert property (!read_valid |-> $stable(read_byte))
    else $error("read byte moved without answer");
  ptr_load_a: assert property (pointer_write |=> address_pointer == $past(write_byte))
    else $error("pointer not loaded");
  ptr_hold_a: assert property (!pointer_write |=> $stable(address_pointer))
    else $error("pointer moved");
  lock_set_a: assert property (frac_read |=> remote_locked)
    else $error("fraction read did not lock");
  lock_clear_a: assert property (int_read |=> !remote_locked)
    else $error("integer read did not unlock");
  lock_cause_a: assert property ($fell(remote_locked) |-> $past(read_request))
    else $error("lock dropped without read");
  range_set_a: assert property (cfg_write |=> extended_range == $past(write_byte[2]))
    else $error("range bit not taken");
  range_only_a: assert property ($changed(extended_range) |-> $past(data_write))
    else $error("range moved without write");
  frac_zero_a: assert property (read_valid && $past(address_pointer) == 8'h10
    |-> read_byte[5:0] == 6'h00)
    else $error("fraction low bits set");
endmodule
bind temp_result_registers temp_result_props i_props (.sys_clk, .reset_n, .pointer_write,
  .data_write, .write_byte, .read_request, .read_byte, .read_valid, .extended_range,
  .address_pointer, .remote_locked);

// File: sim/temp_host_model.sv
// Purpose: Bus host model issuing register byte strobes.
// Assumes: Strobes change just after rising edges.
// Notes: A read with no answer returns an unknown byte.
`timescale 1ns/1ns
module temp_host_model
(
  input wire logic sys_clk,
  input wire logic read_valid,
  input wire logic [7:0] read_byte,
  output logic pointer_write,
  output logic data_write,
  output logic [7:0] write_byte,
  output logic read_request
);
  initial
  begin
    pointer_write = 1'b0;
    data_write = 1'b0;
    write_byte = 8'h00;
    read_request = 1'b0;
  end
  task ptr(input logic [7:0] a);
    @(posedge sys_clk);
    pointer_write <= 1'b1;
    write_byte <= a;
    @(posedge sys_clk);
    pointer_write <= 1'b0;
    write_byte <= ~a;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    ptr(a);
    @(posedge sys_clk);
    data_write <= 1'b1;
    write_byte <= d;
    @(posedge sys_clk);
    data_write <= 1'b0;
    write_byte <= ~d;
  endtask
  task get(output logic [7:0] d);
    d = 8'hxx;
    @(posedge sys_clk);
    read_request <= 1'b1;
    @(posedge sys_clk);
    read_request <= 1'b0;
    repeat (3)
    begin
      @(negedge sys_clk);
      if (read_valid === 1'b1)
        d = read_byte;
    end
  endtask
endmodule

// File: sim/temp_result_registers_bench.sv
// Purpose: Self-checking bench for the result register block.
// Assumes: Reset rate code gives one result per sample.
// Notes: Scenarios run in order and build on earlier state.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module temp_result_registers_bench;
  logic sys_clk;
  logic reset_n;
  logic pointer_write;
  logic data_write;
  logic [7:0] write_byte;
  logic read_request;
  logic [7:0] read_byte;
  logic read_valid;
  logic sample_valid;
  logic sample_remote;
  logic signed [11:0] sample_value;
  logic remote_short;
  logic extended_range;
  logic [7:0] address_pointer;
  logic remote_locked;
  logic [7:0] v;
  int num_errors = 0;
  int checks = 0;
  temp_result_registers i_dut (.sys_clk, .reset_n, .pointer_write, .data_write,
    .write_byte, .read_request, .read_byte, .read_valid, .sample_valid, .sample_remote,
    .sample_value, .remote_short, .extended_range, .address_pointer, .remote_locked);
  temp_host_model i_host (.sys_clk, .read_valid, .read_byte, .pointer_write,
    .data_write, .write_byte, .read_request);
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task rdc(input logic [7:0] a, input logic [7:0] e);
    i_host.ptr(a);
    i_host.get(v);
    `CHK(v, e)
  endtask
  task samp(input logic r, input int q);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    sample_remote <= r;
    sample_value <= 12'(q);
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    sample_value <= ~12'(q);
    repeat (3) @(posedge sys_clk);
  endtask
  task remote(input int q, input logic [7:0] ei, input logic [7:0] ef);
    samp(1'b1, q);
    rdc(8'h10, ef);
    rdc(8'h01, ei);
  endtask
  task t_reset;
    `CHK(address_pointer, 8'h00)
    i_host.get(v);
    `CHK(v, 8'h00)
    rdc(8'h10, 8'h00);
    rdc(8'h01, 8'h00);
  endtask
  task t_binary;
    samp(1'b0, 103);
    rdc(8'h00, 8'h19);
    remote(42, 8'h0a, 8'h80);
    remote(41, 8'h0a, 8'h40);
    remote(-8, 8'h00, 8'h00);
    remote(600, 8'h7f, 8'h00);
    `CHK(extended_range, 1'b0)
  endtask
  task t_access;
    i_host.wr(8'h00, 8'h55);
    i_host.get(v);
    `CHK(v, 8'h19)
    i_host.get(v);
    `CHK(v, 8'h19)
    rdc(8'h05, 8'h00);
  endtask
  task t_extended;
    i_host.wr(8'h09, 8'h04);
    @(negedge sys_clk);
    `CHK(extended_range, 1'b1)
    rdc(8'h03, 8'h04);
    i_host.wr(8'h0b, 8'h4a);
    rdc(8'h03, 8'h04);
    remote(0, 8'h40, 8'h00);
    remote(-220, 8'h09, 8'h00);
    samp(1'b0, 600);
    rdc(8'h00, 8'hd6);
  endtask
  task t_lock;
    samp(1'b1, 401);
    rdc(8'h10, 8'h40);
    `CHK(remote_locked, 1'b1)
    samp(1'b1, 4);
    rdc(8'h01, 8'ha4);
    `CHK(remote_locked, 1'b0)
  endtask
  task t_short;
    samp(1'b1, 40);
    remote_short <= 1'b1;
    samp(1'b1, 300);
    remote_short <= 1'b0;
    rdc(8'h10, 8'h00);
    rdc(8'h01, 8'h4a);
  endtask
  task t_average;
    i_host.wr(8'h0a, 8'h04);
    rdc(8'h04, 8'h04);
    for (int i = 0; i < 15; i++)
      samp(1'b1, (i % 2) ? 48 : 40);
    rdc(8'h01, 8'h4a);
    samp(1'b1, 48);
    rdc(8'h01, 8'h4b);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up;
  end
  initial
  begin
    reset_n = 1'b0;
    sample_valid = 1'b0;
    sample_remote = 1'b0;
    sample_value = 12'h000;
    remote_short = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_binary;
    t_access;
    t_extended;
    t_lock;
    t_short;
    t_average;
    wrap_up;
  end
endmodule
